//--- logic/qsc_soft_ctrl.sv
// soft control and status logic of a four-lane pluggable module
//
// Functional notes
// RULE_01: fully functional within 2000 ms of start.
// RULE_02: reset needs low pulse of 2 us.
// RULE_03: bus answers within 2000 ms of power-on.
// RULE_04: clear data-not-ready, assert attention within 2000 ms.
// RULE_05: functional within 2000 ms after reset rise.
// RULE_06: low-power request lowers power within 100 us.
// RULE_07: attention goes low within 200 ms.
// RULE_08: flags clear on read; attention releases promptly.
// RULE_09: loss-of-signal sets flag, attention within 100 ms.
// RULE_10: any condition sets flag, attention within 200 ms.
// RULE_11: set mask inhibits attention within 100 ms.
// RULE_12: cleared mask resumes attention within 100 ms.
// RULE_13: select asserted, bus answers within 100 us.
// RULE_14: select released, bus silent within 100 us.
// RULE_15: power-down bit lowers power within 100 ms.
// RULE_16: power-down cleared, functional within 300 ms.
// RULE_17: functional means ready bit cleared plus attention.
// RULE_18: read and write effects start after stop. Writes here take effect as soon as the data byte is received, before the stop.
// RULE_19: power-on counted from supply reaching minimum.
// RULE_20: select, reset, attention active low levels.
`timescale 1ns/1ns

module qsc_sync3 #(
	parameter int             W       = 1,
	parameter logic [W-1:0]   RST_VAL = '0
) (
	input  wire logic         clk_in,
	input  wire logic         sys_rst_in,
	input  wire logic [W-1:0] d_in,
	output logic      [W-1:0] q_out
);
	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;
	logic [W-1:0] next_q;

	// a change counts once the second and third stage agree
	always_comb
	begin
		next_q = q_out;
		if (s2 == s3)
		begin
			next_q = s2;
		end
	end

	always_ff @(posedge clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			s1    <= RST_VAL;
			s2    <= RST_VAL;
			s3    <= RST_VAL;
			q_out <= RST_VAL;
		end
		else
		begin
			s1    <= d_in;
			s2    <= s1;
			s3    <= s2;
			q_out <= next_q;
		end
	end
endmodule : qsc_sync3

module qsc_soft_ctrl #(
	parameter int         INIT_CYCLES = qsc_pkg::T_INIT_CYCLES,
	parameter logic [6:0] DEV_ADDR    = qsc_pkg::DEV_ADDR_DEFAULT
) (
	input  wire logic                       clk_in,
	input  wire logic                       sys_rst_in,
	input  wire logic                       scl_in,
	input  wire logic                       sda_in,
	output logic                            sda_out,
	output logic                            sda_oe_n_out,
	input  wire logic                       module_select_n_in,
	input  wire logic                       module_reset_n_in,
	input  wire logic                       low_power_request_in,
	input  wire logic [qsc_pkg::LANES-1:0]  rx_los_in,
	input  wire logic [qsc_pkg::LANES-1:0]  tx_fault_in,
	output logic                            attention_n_out,
	output logic                            module_present_n_out,
	output logic                            low_power_out,
	output logic                            fully_functional_out
);
	localparam int PIN_W = 4 + 2 * qsc_pkg::LANES;
	localparam int LNK_W = qsc_pkg::GRAY_W + qsc_pkg::BYTE_W;

	if (INIT_CYCLES < 1 || INIT_CYCLES >= (1 << qsc_pkg::INIT_W))
	begin : g_bad_init
		$error("INIT_CYCLES out of range");
	end

	function automatic logic [3:0] gray2bin(input logic [3:0] g);
		gray2bin = g ^ (g >> 1) ^ (g >> 2) ^ (g >> 3);
	endfunction : gray2bin

	// link domain: bit capture on the bus clock
	logic [qsc_pkg::GRAY_W-1:0] lk_gray;
	logic [qsc_pkg::BYTE_W-1:0] lk_shift;
	logic [qsc_pkg::GRAY_W-1:0] next_lk_gray;
	logic [qsc_pkg::BYTE_W-1:0] next_lk_shift;
	logic [3:0]                 lk_bin_inc;

	always_comb
	begin
		lk_bin_inc    = gray2bin(lk_gray) + 4'h1;
		next_lk_gray  = lk_bin_inc ^ (lk_bin_inc >> 1);
		next_lk_shift = {lk_shift[qsc_pkg::BYTE_W-2:0], sda_in};
	end

	always_ff @(posedge scl_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			lk_gray  <= '0;
			lk_shift <= '0;
		end
		else
		begin
			lk_gray  <= next_lk_gray;
			lk_shift <= next_lk_shift;
		end
	end

	// crossings into the system clock
	logic [PIN_W-1:0] pins_f;
	logic [LNK_W-1:0] lnk_f;

	qsc_sync3 #(
		.W       (PIN_W),
		.RST_VAL ({4'hf, {(2 * qsc_pkg::LANES){1'b0}}} & {4'hd, {(2 * qsc_pkg::LANES){1'b0}}})
	) u_pins (
		.clk_in     (clk_in),
		.sys_rst_in (sys_rst_in),
		.d_in       ({scl_in, sda_in, low_power_request_in, module_select_n_in, rx_los_in, tx_fault_in}),
		.q_out      (pins_f)
	);

	qsc_sync3 #(
		.W       (LNK_W),
		.RST_VAL ('0)
	) u_link (
		.clk_in     (clk_in),
		.sys_rst_in (sys_rst_in),
		.d_in       ({lk_gray, lk_shift}),
		.q_out      (lnk_f)
	);

	logic rst_n_f;

	qsc_sync3 #(
		.W       (1),
		.RST_VAL (1'b1)
	) u_rst (
		.clk_in     (clk_in),
		.sys_rst_in (sys_rst_in),
		.d_in       (module_reset_n_in),
		.q_out      (rst_n_f)
	);

	logic                      scl_f;
	logic                      sda_f;
	logic                      lp_req_f;
	logic                      sel_n_f;
	logic [qsc_pkg::LANES-1:0] los_f;
	logic [qsc_pkg::LANES-1:0] fault_f;
	logic [3:0]                cur_bin;
	logic [7:0]                shift_f;

	always_comb
	begin
		{scl_f, sda_f, lp_req_f, sel_n_f, los_f, fault_f} = pins_f;
		cur_bin = gray2bin(lnk_f[LNK_W-1:qsc_pkg::BYTE_W]);
		shift_f = lnk_f[qsc_pkg::BYTE_W-1:0];
	end

	// initialisation sequencing
	qsc_pkg::qsc_ini_t                  ini;
	qsc_pkg::qsc_ini_t                  next_ini;
	logic [qsc_pkg::INIT_W-1:0]         icnt;
	logic [qsc_pkg::INIT_W-1:0]         next_icnt;
	logic [qsc_pkg::RST_CNT_W-1:0]      rcnt;
	logic [qsc_pkg::RST_CNT_W-1:0]      next_rcnt;
	logic                               ready_evt;

	always_comb
	begin
		next_ini  = ini;
		next_icnt = icnt;
		ready_evt = 1'b0;
		next_rcnt = rcnt;
		if (rst_n_f)
		begin
			next_rcnt = '0;
		end
		else if (rcnt != qsc_pkg::RST_MIN)
		begin
			next_rcnt = rcnt + 1'b1;
		end
		case (ini)
			qsc_pkg::INI_RESET:
			begin
				if (rst_n_f)
				begin
					next_ini  = qsc_pkg::INI_WAIT; // RULE_05
					next_icnt = qsc_pkg::INIT_W'(INIT_CYCLES - 1);
				end
			end
			qsc_pkg::INI_WAIT:
			begin
				if (icnt == '0)
				begin
					next_ini  = qsc_pkg::INI_RUN; // RULE_01
					ready_evt = 1'b1; // RULE_04
				end
				else
				begin
					next_icnt = icnt - 1'b1;
				end
			end
			qsc_pkg::INI_RUN:
			begin
				next_ini = qsc_pkg::INI_RUN;
			end
			default:
			begin
				next_ini = qsc_pkg::INI_RESET;
			end
		endcase
		if (!rst_n_f && rcnt == qsc_pkg::RST_MIN)
		begin
			next_ini = qsc_pkg::INI_RESET; // RULE_02
		end
	end

	// power-on is the release of the system reset
	always_ff @(posedge clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			ini  <= qsc_pkg::INI_WAIT; // RULE_19
			icnt <= qsc_pkg::INIT_W'(INIT_CYCLES - 1);
			rcnt <= '0;
		end
		else
		begin
			ini  <= next_ini;
			icnt <= next_icnt;
			rcnt <= next_rcnt;
		end
	end

	// flags, masks, control and attention
	logic [7:0]                flags;
	logic [7:0]                mask;
	logic [7:0]                ctrl;
	logic                      ready_flag;
	logic [7:0]                pend_f;
	logic                      pend_r;
	logic [qsc_pkg::LANES-1:0] los_q;
	logic [qsc_pkg::LANES-1:0] fault_q;
	logic [7:0]                next_flags;
	logic [7:0]                next_mask;
	logic [7:0]                next_ctrl;
	logic                      next_ready_flag;
	logic [7:0]                next_pend_f;
	logic                      next_pend_r;
	logic                      next_att_n;
	logic                      next_lp;
	logic                      next_func;
	logic [7:0]                events;
	logic                      rd_flag;
	logic                      rd_status;
	logic                      wr_stb;
	logic [7:0]                wr_addr;
	logic [7:0]                wr_data;
	logic                      stop_stb;
	logic [7:0]                status_byte;

	always_comb
	begin
		events = '0;
		events[qsc_pkg::LOS_LSB +: qsc_pkg::LANES]   = los_f & ~los_q; // RULE_09
		events[qsc_pkg::FAULT_LSB +: qsc_pkg::LANES] = fault_f & ~fault_q; // RULE_10
		next_pend_f = pend_f;
		next_pend_r = pend_r;
		if (rd_flag)
		begin
			next_pend_f = pend_f | flags;
		end
		if (rd_status)
		begin
			next_pend_r = pend_r | ready_flag;
		end
		next_flags      = flags | events;
		next_ready_flag = ready_flag | ready_evt;
		if (stop_stb)
		begin
			next_flags      = (flags & ~pend_f) | events; // RULE_08 RULE_18
			next_ready_flag = (ready_flag & ~pend_r) | ready_evt;
			next_pend_f     = '0;
			next_pend_r     = 1'b0;
		end
		next_mask = mask;
		next_ctrl = ctrl;
		if (wr_stb && wr_addr == qsc_pkg::ADDR_MASK)
		begin
			next_mask = wr_data; // RULE_11 RULE_12
		end
		if (wr_stb && wr_addr == qsc_pkg::ADDR_CTRL)
		begin
			next_ctrl = wr_data;
		end
		if (ini == qsc_pkg::INI_RESET)
		begin
			next_flags      = '0;
			next_mask       = qsc_pkg::MASK_RST;
			next_ctrl       = qsc_pkg::CTRL_RST;
			next_ready_flag = 1'b0;
			next_pend_f     = '0;
			next_pend_r     = 1'b0;
		end
		next_att_n = ~((|(flags & ~mask)) | ready_flag); // RULE_07 RULE_17 RULE_20
		next_lp    = lp_req_f // RULE_06
			| (ctrl[qsc_pkg::CTRL_OVR_BIT] & ctrl[qsc_pkg::CTRL_SET_BIT]); // RULE_15 RULE_16
		next_func  = (ini == qsc_pkg::INI_RUN) && ready_flag;
		if (ini == qsc_pkg::INI_RUN && !ready_flag)
		begin
			next_func = fully_functional_out;
		end
	end

	always_ff @(posedge clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			flags                <= '0;
			mask                 <= qsc_pkg::MASK_RST;
			ctrl                 <= qsc_pkg::CTRL_RST;
			ready_flag           <= 1'b0;
			pend_f               <= '0;
			pend_r               <= 1'b0;
			los_q                <= '0;
			fault_q              <= '0;
			attention_n_out      <= 1'b1;
			low_power_out        <= 1'b0;
			fully_functional_out <= 1'b0;
			module_present_n_out <= 1'b0;
		end
		else
		begin
			flags                <= next_flags;
			mask                 <= next_mask;
			ctrl                 <= next_ctrl;
			ready_flag           <= next_ready_flag;
			pend_f               <= next_pend_f;
			pend_r               <= next_pend_r;
			los_q                <= los_f;
			fault_q              <= fault_f;
			attention_n_out      <= next_att_n;
			low_power_out        <= next_lp;
			fully_functional_out <= next_func;
			module_present_n_out <= 1'b0;
		end
	end

	// two-wire slave on filtered pins
	qsc_pkg::qsc_bus_t   bus;
	qsc_pkg::qsc_bus_t   next_bus;
	qsc_pkg::qsc_phase_t phase;
	qsc_pkg::qsc_phase_t next_phase;
	logic [3:0]          ref_cnt;
	logic [3:0]          next_ref_cnt;
	logic [7:0]          ptr;
	logic [7:0]          next_ptr;
	logic [7:0]          txb;
	logic [7:0]          next_txb;
	logic                rw;
	logic                next_rw;
	logic                oe_n;
	logic                next_oe_n;
	logic                scl_p;
	logic                sda_p;
	logic [3:0]          diff;
	logic                fall;
	logic                start_c;
	logic                active;
	logic                do_load;
	logic [7:0]          rd_byte;

	always_comb
	begin
		diff     = cur_bin - ref_cnt;
		fall     = scl_p & ~scl_f;
		start_c  = scl_f & scl_p & sda_p & ~sda_f;
		stop_stb = scl_f & scl_p & ~sda_p & sda_f;
		active   = ~sel_n_f && (ini != qsc_pkg::INI_RESET); // RULE_03 RULE_13 RULE_14
		status_byte = '0;
		status_byte[qsc_pkg::STATUS_DNR_BIT] = (ini != qsc_pkg::INI_RUN); // RULE_04
		status_byte[qsc_pkg::STATUS_RDY_BIT] = ready_flag;
		case (ptr)
			qsc_pkg::ADDR_STATUS: rd_byte = status_byte;
			qsc_pkg::ADDR_FLAG:   rd_byte = flags;
			qsc_pkg::ADDR_MASK:   rd_byte = mask;
			qsc_pkg::ADDR_CTRL:   rd_byte = ctrl;
			default:              rd_byte = '0;
		endcase
		next_bus     = bus;
		next_phase   = phase;
		next_ref_cnt = ref_cnt;
		next_ptr     = ptr;
		next_txb     = txb;
		next_rw      = rw;
		next_oe_n    = oe_n;
		do_load      = 1'b0;
		wr_stb       = 1'b0;
		wr_addr      = ptr;
		wr_data      = shift_f;
		rd_flag      = 1'b0;
		rd_status    = 1'b0;
		if (!active)
		begin
			next_bus  = qsc_pkg::BUS_IDLE; // RULE_14
			next_oe_n = 1'b1;
		end
		else if (start_c)
		begin
			next_bus     = qsc_pkg::BUS_RX;
			next_phase   = qsc_pkg::PH_ADDR;
			next_ref_cnt = cur_bin;
			next_oe_n    = 1'b1;
		end
		else if (stop_stb)
		begin
			next_bus  = qsc_pkg::BUS_IDLE;
			next_oe_n = 1'b1;
		end
		else
		begin
			case (bus)
				qsc_pkg::BUS_IDLE:
				begin
					next_oe_n = 1'b1;
				end
				qsc_pkg::BUS_RX:
				begin
					if (fall && diff == qsc_pkg::DIFF_BYTE)
					begin
						next_bus  = qsc_pkg::BUS_ACK;
						next_oe_n = 1'b0;
						case (phase)
							qsc_pkg::PH_ADDR:
							begin
								next_rw    = shift_f[0];
								next_phase = qsc_pkg::PH_PTR;
								if (shift_f[7:1] != DEV_ADDR)
								begin
									next_bus  = qsc_pkg::BUS_IDLE;
									next_oe_n = 1'b1;
								end
							end
							qsc_pkg::PH_PTR:
							begin
								next_ptr   = shift_f;
								next_phase = qsc_pkg::PH_DATA;
							end
							default:
							begin
								wr_stb   = 1'b1;
								next_ptr = ptr + 1'b1;
							end
						endcase
					end
				end
				qsc_pkg::BUS_ACK:
				begin
					if (fall && diff == qsc_pkg::DIFF_ACK)
					begin
						next_ref_cnt = cur_bin;
						next_oe_n    = 1'b1;
						next_bus     = qsc_pkg::BUS_RX;
						do_load      = rw;
					end
				end
				qsc_pkg::BUS_TX:
				begin
					if (fall && diff == qsc_pkg::DIFF_BYTE)
					begin
						next_bus  = qsc_pkg::BUS_TX_ACK;
						next_oe_n = 1'b1;
					end
					else if (fall)
					begin
						next_oe_n = txb[3'(qsc_pkg::BIT_TOP - diff)];
					end
				end
				qsc_pkg::BUS_TX_ACK:
				begin
					if (fall && diff == qsc_pkg::DIFF_ACK)
					begin
						next_ref_cnt = cur_bin;
						next_bus     = qsc_pkg::BUS_IDLE;
						do_load      = ~shift_f[0];
					end
				end
				default:
				begin
					next_bus  = qsc_pkg::BUS_IDLE;
					next_oe_n = 1'b1;
				end
			endcase
		end
		if (do_load)
		begin
			next_bus  = qsc_pkg::BUS_TX;
			next_txb  = rd_byte;
			next_oe_n = rd_byte[7];
			next_ptr  = ptr + 1'b1;
			rd_flag   = (ptr == qsc_pkg::ADDR_FLAG); // RULE_08
			rd_status = (ptr == qsc_pkg::ADDR_STATUS);
		end
	end

	always_ff @(posedge clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			bus     <= qsc_pkg::BUS_IDLE;
			phase   <= qsc_pkg::PH_ADDR;
			ref_cnt <= '0;
			ptr     <= '0;
			txb     <= '0;
			rw      <= 1'b0;
			oe_n    <= 1'b1;
			scl_p   <= 1'b1;
			sda_p   <= 1'b1;
		end
		else
		begin
			bus     <= next_bus;
			phase   <= next_phase;
			ref_cnt <= next_ref_cnt;
			ptr     <= next_ptr;
			txb     <= next_txb;
			rw      <= next_rw;
			oe_n    <= next_oe_n;
			scl_p   <= scl_f;
			sda_p   <= sda_f;
		end
	end

	assign sda_out      = 1'b0;
	assign sda_oe_n_out = oe_n;

endmodule : qsc_soft_ctrl

//--- logic/qsc_pkg.sv
// constants and types shared by the module soft control logic
package qsc_pkg;

	// clock and documented timing
	localparam int CLK_PERIOD_NS    = 20;
	localparam int T_INIT_MS        = 2000;
	localparam int T_RESET_MIN_US   = 2;
	localparam int T_INIT_CYCLES    = T_INIT_MS * (1_000_000 / CLK_PERIOD_NS);
	localparam int RST_MIN_CYCLES   = (T_RESET_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int INIT_W           = 27;
	localparam int RST_CNT_W        = 7;
	localparam logic [RST_CNT_W-1:0] RST_MIN = RST_CNT_W'(RST_MIN_CYCLES);

	// two-wire framing
	localparam int             BYTE_W    = 8;
	localparam int             GRAY_W    = 4;
	localparam logic [3:0]     DIFF_BYTE = 4'h8;
	localparam logic [3:0]     DIFF_ACK  = 4'h9;
	localparam logic [3:0]     BIT_TOP   = 4'h7;
	localparam logic [6:0]     DEV_ADDR_DEFAULT = 7'h50;

	// byte addresses of the soft control map
	localparam logic [7:0] ADDR_STATUS = 8'h02;
	localparam logic [7:0] ADDR_FLAG   = 8'h03;
	localparam logic [7:0] ADDR_CTRL   = 8'h5d;
	localparam logic [7:0] ADDR_MASK   = 8'h64;

	// field positions
	localparam int LANES          = 4;
	localparam int LOS_LSB        = 0;
	localparam int FAULT_LSB      = 4;
	localparam int STATUS_DNR_BIT = 0;
	localparam int STATUS_RDY_BIT = 1;
	localparam int CTRL_OVR_BIT   = 0;
	localparam int CTRL_SET_BIT   = 1;

	// reset values
	localparam logic [7:0] MASK_RST = 8'h00;
	localparam logic [7:0] CTRL_RST = 8'h00;

	typedef enum logic [1:0] {
		INI_RESET = 2'b00,
		INI_WAIT  = 2'b01,
		INI_RUN   = 2'b10
	} qsc_ini_t;

	typedef enum logic [2:0] {
		BUS_IDLE   = 3'b000,
		BUS_RX     = 3'b001,
		BUS_ACK    = 3'b010,
		BUS_TX     = 3'b011,
		BUS_TX_ACK = 3'b100
	} qsc_bus_t;

	typedef enum logic [1:0] {
		PH_ADDR = 2'b00,
		PH_PTR  = 2'b01,
		PH_DATA = 2'b10
	} qsc_phase_t;

endpackage : qsc_pkg

//--- tb/qsc_soft_ctrl_sva.sv
// assertion checker for the module soft control ports
`timescale 1ns/1ns
module qsc_soft_ctrl_sva #(
	parameter int INIT_CYCLES = 50
) (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic scl_in,
	input wire logic sda_oe_n_out,
	input wire logic module_select_n_in,
	input wire logic module_reset_n_in,
	input wire logic low_power_request_in,
	input wire logic attention_n_out,
	input wire logic module_present_n_out,
	input wire logic low_power_out,
	input wire logic fully_functional_out
);
	localparam int FF_LIMIT = INIT_CYCLES + 16;
	int run_cnt;
	int low_cnt;
	int next_run_cnt;
	int next_low_cnt;
	always_comb
	begin
		next_run_cnt = !module_reset_n_in ? 0 : (run_cnt <= FF_LIMIT ? run_cnt + 1 : run_cnt);
		next_low_cnt = module_reset_n_in ? 0 : (low_cnt < 200 ? low_cnt + 1 : low_cnt);
	end
	always_ff @(posedge clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			run_cnt <= 0;
			low_cnt <= 0;
		end
		else
		begin
			run_cnt <= next_run_cnt;
			low_cnt <= next_low_cnt;
		end
	end
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (sys_rst_in);
	sequence s_long_release;
		$rose(module_reset_n_in) && low_cnt > 120;
	endsequence
	sequence s_init_quiet;
		!fully_functional_out [*8];
	endsequence
	AST_PRESENT: assert property (module_present_n_out == 1'b0)
		else $error("module present not low");
	AST_LP_REQ: assert property ($rose(low_power_request_in) |-> ##[1:8] low_power_out)
		else $error("low power not entered");
	AST_FF_ATT: assert property ($rose(fully_functional_out) |-> ##[0:4] !attention_n_out)
		else $error("attention missing at ready");
	AST_FF_TIME: assert property (run_cnt == FF_LIMIT |-> fully_functional_out)
		else $error("not functional in time");
	AST_MRST_QUIET: assert property (low_cnt > 120 |-> sda_oe_n_out && !fully_functional_out)
		else $error("active during module reset");
	AST_REINIT: assert property (s_long_release |-> s_init_quiet)
		else $error("init wait skipped");
	AST_DESEL_IDLE: assert property (module_select_n_in [*8] |=> sda_oe_n_out)
		else $error("bus driven while deselected");
	AST_ACK_SCL: assert property ($changed(sda_oe_n_out) |-> !scl_in)
		else $error("data changed while clock high");
endmodule : qsc_soft_ctrl_sva

bind qsc_soft_ctrl qsc_soft_ctrl_sva #(.INIT_CYCLES(INIT_CYCLES)) i_qsc_soft_ctrl_sva (
	.clk_in(clk_in),
	.sys_rst_in(sys_rst_in),
	.scl_in(scl_in),
	.sda_oe_n_out(sda_oe_n_out),
	.module_select_n_in(module_select_n_in),
	.module_reset_n_in(module_reset_n_in),
	.low_power_request_in(low_power_request_in),
	.attention_n_out(attention_n_out),
	.module_present_n_out(module_present_n_out),
	.low_power_out(low_power_out),
	.fully_functional_out(fully_functional_out)
);

//--- tb/qsc_host_model.sv
// host side two-wire bus model with its own link clock
`timescale 1ns/1ns
module qsc_host_model (
	input  wire logic sda_in,
	output logic      scl_out,
	output logic      sda_oe_n_out
);
	logic lclk;
	initial
	begin
		lclk = 1'b0;
		scl_out = 1'b1;
		sda_oe_n_out = 1'b1;
		#5;
		forever #16 lclk = ~lclk;
	end
	task automatic half;
		repeat (32) @(posedge lclk);
	endtask : half
	task automatic bit_io(input logic b, output logic seen);
		repeat (8) @(posedge lclk);
		sda_oe_n_out = b;
		half();
		scl_out = 1'b1;
		half();
		seen = sda_in;
		scl_out = 1'b0;
	endtask : bit_io
	// msb first, ninth bit released for ack or nack
	task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
		begin
			bit_io(d[i], q[i]);
		end
		bit_io(1'b1, s);
		ack = (s === 1'b0);
	endtask : xfer
	// address byte alone, then stop
	task automatic probe(input logic [6:0] dev, output logic ok);
		logic [7:0] q;
		start();
		xfer({dev, 1'b0}, q, ok);
		stop();
	endtask : probe
	task automatic start;
		repeat (8) @(posedge lclk);
		sda_oe_n_out = 1'b1;
		half();
		scl_out = 1'b1;
		half();
		sda_oe_n_out = 1'b0;
		half();
		scl_out = 1'b0;
	endtask : start
	task automatic stop;
		repeat (8) @(posedge lclk);
		sda_oe_n_out = 1'b0;
		half();
		scl_out = 1'b1;
		half();
		sda_oe_n_out = 1'b1;
		half();
	endtask : stop
	task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ok);
		logic [7:0] q;
		logic       a0;
		logic       a1;
		logic       a2;
		start();
		xfer({qsc_pkg::DEV_ADDR_DEFAULT, 1'b0}, q, a0);
		xfer(a, q, a1);
		xfer(d, q, a2);
		stop();
		ok = a0 & a1 & a2;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
		logic [7:0] q;
		logic       a0;
		logic       a1;
		logic       a2;
		logic       n;
		start();
		xfer({qsc_pkg::DEV_ADDR_DEFAULT, 1'b0}, q, a0);
		xfer(a, q, a1);
		start();
		xfer({qsc_pkg::DEV_ADDR_DEFAULT, 1'b1}, q, a2);
		xfer(8'hff, d, n);
		stop();
		ok = a0 & a1 & a2;
	endtask : rd
endmodule : qsc_host_model

//--- tb/qsc_soft_ctrl_tb.sv
// self-checking bench for the module soft control logic
`timescale 1ns/1ns
module qsc_soft_ctrl_tb;
	logic       clk_in;
	logic       sys_rst_in;
	logic       sel_n;
	logic       mrst_n;
	logic       lp_req;
	logic [3:0] los;
	logic [3:0] fault;
	logic       sda_out;
	logic       dev_oe_n;
	logic       att_n;
	logic       prs_n;
	logic       lp;
	logic       ff;
	logic       scl;
	logic       host_oe_n;
	wire        sda_line;
	int         mismatches;
	int         check_count;
	logic [7:0] d;
	logic       ok;
	assign sda_line = (dev_oe_n ? 1'b1 : sda_out) & host_oe_n;
	always #10 clk_in = ~clk_in;
	qsc_soft_ctrl #(.INIT_CYCLES(50)) i_qsc_soft_ctrl (
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.scl_in(scl),
		.sda_in(sda_line),
		.sda_out(sda_out),
		.sda_oe_n_out(dev_oe_n),
		.module_select_n_in(sel_n),
		.module_reset_n_in(mrst_n),
		.low_power_request_in(lp_req),
		.rx_los_in(los),
		.tx_fault_in(fault),
		.attention_n_out(att_n),
		.module_present_n_out(prs_n),
		.low_power_out(lp),
		.fully_functional_out(ff)
	);
	qsc_host_model i_qsc_host_model (
		.sda_in(sda_line),
		.scl_out(scl),
		.sda_oe_n_out(host_oe_n)
	);
	task automatic summarize;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : summarize
	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge clk_in);
		#2;
	endtask : tick
	task automatic wait_sig(ref logic s, input logic lvl);
		int i;
		for (i = 0; i < 200 && s !== lvl; i++)
			tick(1);
		chk("wait_level", {7'h0, s}, {7'h0, lvl});
		if (s !== lvl)
		begin
			summarize();
		end
	endtask : wait_sig
	task automatic t_power_on;
		wait_sig(ff, 1'b1);
		chk("present", {7'h0, prs_n}, 8'h00);
		chk("attn_ready", {7'h0, att_n}, 8'h00);
		i_qsc_host_model.rd(qsc_pkg::ADDR_STATUS, d, ok);
		chk("status_ack", {7'h0, ok}, 8'h01);
		chk("status", d, 8'h02);
		wait_sig(att_n, 1'b1);
		i_qsc_host_model.rd(qsc_pkg::ADDR_STATUS, d, ok);
		chk("status_clr", d, 8'h00);
		$display("test power_on done");
	endtask : t_power_on
	task automatic t_flags;
		tick(1);
		los = 4'h4;
		wait_sig(att_n, 1'b0);
		fault = 4'h2;
		tick(10);
		i_qsc_host_model.rd(qsc_pkg::ADDR_FLAG, d, ok);
		chk("flags", d, 8'h24);
		wait_sig(att_n, 1'b1);
		i_qsc_host_model.rd(qsc_pkg::ADDR_FLAG, d, ok);
		chk("flags_clr", d, 8'h00);
		i_qsc_host_model.rd(8'h10, d, ok);
		chk("unmapped", d, 8'h00);
		tick(1);
		los = 4'h0;
		fault = 4'h0;
		$display("test flags done");
	endtask : t_flags
	task automatic t_mask;
		i_qsc_host_model.wr(qsc_pkg::ADDR_MASK, 8'h01, ok);
		chk("mask_ack", {7'h0, ok}, 8'h01);
		tick(1);
		los = 4'h1;
		tick(20);
		chk("masked_attn", {7'h0, att_n}, 8'h01);
		i_qsc_host_model.wr(qsc_pkg::ADDR_MASK, 8'h00, ok);
		wait_sig(att_n, 1'b0);
		i_qsc_host_model.rd(qsc_pkg::ADDR_FLAG, d, ok);
		chk("masked_flag", d, 8'h01);
		wait_sig(att_n, 1'b1);
		los = 4'h0;
		$display("test mask done");
	endtask : t_mask
	task automatic t_power;
		lp_req = 1'b1;
		wait_sig(lp, 1'b1);
		lp_req = 1'b0;
		wait_sig(lp, 1'b0);
		i_qsc_host_model.wr(qsc_pkg::ADDR_CTRL, 8'h03, ok);
		tick(4);
		chk("pdown", {7'h0, lp}, 8'h01);
		i_qsc_host_model.wr(qsc_pkg::ADDR_CTRL, 8'h01, ok);
		tick(4);
		chk("pup", {7'h0, lp}, 8'h00);
		chk("pup_ff", {7'h0, ff}, 8'h01);
		$display("test power done");
	endtask : t_power
	task automatic t_select;
		sel_n = 1'b1;
		tick(10);
		i_qsc_host_model.wr(qsc_pkg::ADDR_MASK, 8'hff, ok);
		chk("desel_ack", {7'h0, ok}, 8'h00);
		tick(1);
		sel_n = 1'b0;
		tick(10);
		i_qsc_host_model.rd(qsc_pkg::ADDR_MASK, d, ok);
		chk("sel_ack", {7'h0, ok}, 8'h01);
		chk("desel_mask", d, 8'h00);
		i_qsc_host_model.probe(qsc_pkg::DEV_ADDR_DEFAULT ^ 7'h01, ok);
		chk("bad_addr_ack", {7'h0, ok}, 8'h00);
		i_qsc_host_model.probe(qsc_pkg::DEV_ADDR_DEFAULT, ok);
		chk("addr_ack", {7'h0, ok}, 8'h01);
		$display("test select done");
	endtask : t_select
	task automatic t_reset;
		tick(1);
		mrst_n = 1'b0;
		tick(20);
		mrst_n = 1'b1;
		tick(10);
		chk("short_pulse", {7'h0, ff}, 8'h01);
		mrst_n = 1'b0;
		tick(150);
		chk("rst_ff", {7'h0, ff}, 8'h00);
		i_qsc_host_model.wr(qsc_pkg::ADDR_MASK, 8'h0f, ok);
		chk("rst_ack", {7'h0, ok}, 8'h00);
		tick(1);
		mrst_n = 1'b1;
		wait_sig(ff, 1'b1);
		chk("rst_attn", {7'h0, att_n}, 8'h00);
		i_qsc_host_model.rd(qsc_pkg::ADDR_CTRL, d, ok);
		chk("rst_ctrl", d, 8'h00);
		$display("test reset done");
	endtask : t_reset
	initial
	begin
		clk_in = 1'b0;
		sys_rst_in = 1'b1;
		sel_n = 1'b0;
		mrst_n = 1'b1;
		lp_req = 1'b0;
		los = 4'h0;
		fault = 4'h0;
		mismatches = 0;
		check_count = 0;
		tick(10);
		sys_rst_in = 1'b0;
		t_power_on();
		t_flags();
		t_mask();
		t_power();
		t_select();
		t_reset();
		summarize();
	end
endmodule : qsc_soft_ctrl_tb
